// [hdl/mel_pkg.sv]
// Purpose: shared constants and types of the multi event latch front-panel block
// Assumes: 200 MHz pclk, APB register access, one VME address modifier per transfer
// Notes:   byte offsets are the printed ones; all other offsets are local choices
package mel_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ         = 200;
	localparam int unsigned CIP_DELAY_NS    = 25;
	localparam int unsigned CIP_DELAY_CYC   = (CIP_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned PULSER_MHZ      = 10;
	localparam int unsigned PULSER_HALF_CYC = CLK_MHZ / (2 * PULSER_MHZ);
	localparam int unsigned INIT_TIME_US    = 1000;
	localparam int unsigned INIT_CYC_DEF    = INIT_TIME_US * CLK_MHZ;
	localparam int unsigned DLY_W           = 3;
	localparam int unsigned PCNT_W          = 4;
	localparam int unsigned INIT_W          = 20;

	// ----------------------------------------------------------------
	// widths, fifo, register map
	// ----------------------------------------------------------------
	localparam int unsigned DW         = 32;
	localparam int unsigned AW         = 12;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned FIFO_AW    = 4;
	localparam int unsigned WIN_W      = 16;
	localparam logic [FIFO_AW:0] FIFO_HALF = 5'h08;
	localparam logic [FIFO_AW:0] FIFO_FULL = 5'h10;

	localparam logic [AW-1:0] OFS_CTRL    = 12'h000;
	localparam logic [AW-1:0] OFS_WINDOW  = 12'h008;
	localparam logic [AW-1:0] OFS_ADDREN  = 12'h00C;
	localparam logic [AW-1:0] OFS_STROBE  = 12'h010;
	localparam logic [AW-1:0] OFS_FIFO_LO = 12'h100;
	localparam logic [AW-1:0] OFS_FIFO_HI = 12'h1FC;

	// control bits: set with bit n, clear with bit n+CB_CLR
	localparam int unsigned CB_N     = 7;
	localparam int unsigned CB_CLR   = 8;
	localparam int unsigned CB_USER  = 0;
	localparam int unsigned CB_FTEST = 1;
	localparam int unsigned CB_MODE0 = 2;
	localparam int unsigned CB_MODE1 = 3;
	localparam int unsigned CB_COINC = 4;
	localparam int unsigned CB_DISC  = 5;
	localparam int unsigned CB_PULSE = 6;
	localparam logic [CB_N-1:0] CTRL_RST = 7'h00;

	// status bits on read of the control word
	localparam int unsigned ST_EMPTY = 8;
	localparam int unsigned ST_HALF  = 9;
	localparam int unsigned ST_FULL  = 10;
	localparam int unsigned ST_CIP   = 11;

	localparam logic [WIN_W-1:0] WIN_RST    = 16'h0010;
	localparam logic [2:0]       ADDREN_RST = 3'h7;
	localparam int unsigned EN_A16 = 0;
	localparam int unsigned EN_A24 = 1;
	localparam int unsigned EN_A32 = 2;

	// ----------------------------------------------------------------
	// address modifiers
	// ----------------------------------------------------------------
	localparam logic [5:0] AM_A24_SBLT = 6'h3F;
	localparam logic [5:0] AM_A24_SDAT = 6'h3D;
	localparam logic [5:0] AM_A24_NBLT = 6'h3B;
	localparam logic [5:0] AM_A24_NDAT = 6'h39;
	localparam logic [5:0] AM_A16_SUP  = 6'h2D;
	localparam logic [5:0] AM_A16_NPR  = 6'h29;
	localparam logic [5:0] AM_A32_SBLT = 6'h0F;
	localparam logic [5:0] AM_A32_SDAT = 6'h0D;
	localparam logic [5:0] AM_A32_NBLT = 6'h0B;
	localparam logic [5:0] AM_A32_NDAT = 6'h09;

	// ----------------------------------------------------------------
	// front panel
	// ----------------------------------------------------------------
	localparam int unsigned CI_STROBE  = 0;
	localparam int unsigned CI_MODRST  = 1;
	localparam int unsigned CI_DISCARD = 2;
	localparam int unsigned LED_N      = 8;
	localparam logic [LED_N-1:0] LED_INIT = 8'hFE;
	localparam logic [LED_N-1:0] LED_RUN  = 8'h03;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic          psel;
		logic          penable;
		logic          pwrite;
		logic [AW-1:0] paddr;
		logic [DW-1:0] pwdata;
		logic [5:0]    am;
	} mel_apb_req_t;

	typedef struct packed {
		logic [DW-1:0] prdata;
		logic          pready;
		logic          pslverr;
	} mel_apb_rsp_t;

	typedef enum logic [1:0] {CAP_IDLE, CAP_GATE, CAP_WINDOW, CAP_COPY} mel_cap_st_t;

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][DW-1:0] mem;
		logic [FIFO_AW-1:0]            wp;
		logic [FIFO_AW-1:0]            rp;
		logic [FIFO_AW:0]              cnt;
		logic [CB_N-1:0]               ctrl;
		logic [WIN_W-1:0]              win;
		logic [2:0]                    addren;
		mel_cap_st_t                   st;
		logic [DW-1:0]                 base;
		logic [DW-1:0]                 word;
		logic [DLY_W-1:0]              dly;
		logic [WIN_W-1:0]              wcnt;
		logic                          stb_prev;
		logic                          disc_prev;
		logic                          soft_stb;
		logic [PCNT_W-1:0]             pcnt;
		logic                          pulse;
		logic [INIT_W-1:0]             icnt;
		logic                          init_done;
		logic [3:0]                    outs;
		logic [LED_N-1:0]              led;
		logic [DW-1:0]                 prdata;
		logic                          pslverr;
	} mel_state_t;

endpackage

// [hdl/mel_latch_ctl.sv]
// Purpose: front-panel control, capture and fifo logic of a 32-channel event latch
// Assumes: inputs synchronous to pclk; APB slave with zero wait states
// Notes:   ctrl_out[0..3] are front-panel control outputs 5..8
//
// What this block does
// - mode 0: out8 fifo full, out7 half full, out6 empty, out5 copy_in_progress.
// - mode 1: out8 full, out7 half full, out6 pulser, out5 copy_in_progress.
// - mode 2: out8 any_channel_hit, out7 user bit, out6 pulser, out5 copy_in_progress.
// - mode 3: all four control outputs carry the test pulser.
// - output mode resets to mode 0.
// - input 1 strobe, input 2 module reset, input 3 discard, input 4 unused.
// - strobed mode captures all data inputs on the strobe leading edge.
// - coincidence mode stores one only for inputs rising during the gate.
// - copy_in_progress rises 25 ns after gate start, holds until fifo write.
// - with discard enabled, a discard pulse or window expiry plus copy ends it.
// - the test pulser runs at 10 MHz.
// - control bit 1 sets fifo test mode, control bit 9 clears it.
// - in fifo test mode writes to 0x100..0x1FC push the word.
// - 24-bit addressing answers modifiers 0x3F, 0x3B, 0x3D, 0x39.
// - 32-bit addressing answers modifiers 0x0F, 0x0B, 0x0D, 0x09.
// - 16-bit addressing answers 0x2D, 0x29; disabled modes are ignored.
// - indicators all lit except ready during init, then only ready and power.
// - reads anywhere in 0x100..0x1FC return the next fifo word.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module mel_latch_ctl #(
	parameter int unsigned INIT_CYC = mel_pkg::INIT_CYC_DEF
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire mel_pkg::mel_apb_req_t   req,
	output mel_pkg::mel_apb_rsp_t        rsp,
	input  wire logic [mel_pkg::DW-1:0]  data_in,
	input  wire logic [3:0]              ctrl_in,
	output logic      [3:0]              ctrl_out,
	output logic      [mel_pkg::LED_N-1:0] led
);
	import mel_pkg::*;

	mel_state_t s_q;
	mel_state_t s_d;
	logic       setup;
	logic       acc;
	logic       am_ok;
	logic       in_fifo;
	logic       mapped;
	logic       f_empty;
	logic       f_half;
	logic       f_full;
	logic       copy_in_progress;
	logic       any_hit;
	logic       gate_rise;
	logic       disc_rise;
	logic [1:0] mode;
	logic [DW-1:0] hit_now;

	// ----------------------------------------------------------------
	// decode and flags
	// ----------------------------------------------------------------
	assign setup   = req.psel & ~req.penable;
	assign acc     = req.psel & req.penable;
	assign in_fifo = (req.paddr >= OFS_FIFO_LO) && (req.paddr <= OFS_FIFO_HI);
	assign mapped  = in_fifo || (req.paddr == OFS_CTRL) || (req.paddr == OFS_WINDOW) ||
	                 (req.paddr == OFS_ADDREN) || (req.paddr == OFS_STROBE);
	assign f_empty = (s_q.cnt == '0);
	assign f_half  = (s_q.cnt >= FIFO_HALF);
	assign f_full  = (s_q.cnt == FIFO_FULL);
	assign mode    = {s_q.ctrl[CB_MODE1], s_q.ctrl[CB_MODE0]};
	assign copy_in_progress     = (s_q.st != CAP_IDLE) && (s_q.dly == DLY_W'(CIP_DELAY_CYC));
	assign any_hit = |data_in;
	assign gate_rise = (ctrl_in[CI_STROBE] & ~s_q.stb_prev) | s_q.soft_stb;
	assign disc_rise = ctrl_in[CI_DISCARD] & ~s_q.disc_prev;
	assign hit_now   = s_q.word | (data_in & ~s_q.base);

	always_comb begin
		unique case (req.am)
			AM_A24_SBLT, AM_A24_NBLT, AM_A24_SDAT, AM_A24_NDAT:
				am_ok = s_q.addren[EN_A24];
			AM_A32_SBLT, AM_A32_NBLT, AM_A32_SDAT, AM_A32_NDAT:
				am_ok = s_q.addren[EN_A32];
			AM_A16_SUP, AM_A16_NPR: am_ok = s_q.addren[EN_A16];
			default: am_ok = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d           = s_q;
		s_d.soft_stb  = 1'b0;
		s_d.stb_prev  = ctrl_in[CI_STROBE];
		s_d.disc_prev = ctrl_in[CI_DISCARD];

		// register reads are answered from a flop loaded in the setup cycle
		if (setup) begin
			s_d.pslverr = ~am_ok | ~mapped;
			s_d.prdata  = '0;
			if (!am_ok) begin
				// an ignored modifier must not leak status or fifo data
				s_d.prdata = '0;
			end else if (in_fifo) begin
				s_d.prdata = f_empty ? '0 : s_q.mem[s_q.rp];
			end else if (req.paddr == OFS_CTRL) begin
				s_d.prdata = DW'({copy_in_progress, f_full, f_half, f_empty, 1'b0, s_q.ctrl});
			end else if (req.paddr == OFS_WINDOW) begin
				s_d.prdata = DW'(s_q.win);
			end else if (req.paddr == OFS_ADDREN) begin
				s_d.prdata = DW'(s_q.addren);
			end
		end

		if (acc && am_ok && req.pwrite) begin
			if (req.paddr == OFS_CTRL) begin
				// paired set/clear; set wins when both are written
				for (int i = 0; i < CB_N; i++) begin
					if (req.pwdata[i]) begin
						s_d.ctrl[i] = 1'b1;
					end else if (req.pwdata[i + CB_CLR]) begin
						s_d.ctrl[i] = 1'b0;
					end
				end
			end
			if (req.paddr == OFS_WINDOW) begin
				s_d.win = req.pwdata[WIN_W-1:0];
			end
			if (req.paddr == OFS_ADDREN) begin
				s_d.addren = req.pwdata[2:0];
			end
			if (req.paddr == OFS_STROBE) begin
				s_d.soft_stb = 1'b1;
			end
			// test writes; capture copies are held off meanwhile
			if (in_fifo && s_q.ctrl[CB_FTEST] && !f_full) begin
				s_d.mem[s_q.wp] = req.pwdata;
				s_d.wp          = s_q.wp + 1'b1;
				s_d.cnt         = s_d.cnt + 1'b1;
			end
		end
		if (acc && am_ok && !req.pwrite && in_fifo && !f_empty) begin
			s_d.rp  = s_q.rp + 1'b1;
			s_d.cnt = s_d.cnt - 1'b1;
		end

		// ----------------------------------------------------------------
		// capture sequence
		// ----------------------------------------------------------------
		if (s_q.st != CAP_IDLE && s_q.dly != DLY_W'(CIP_DELAY_CYC)) begin
			s_d.dly = s_q.dly + 1'b1;
		end
		case (s_q.st)
			CAP_IDLE: begin
				if (gate_rise) begin
					s_d.st   = CAP_GATE;
					s_d.dly  = DLY_W'(1);
					s_d.base = data_in;
					s_d.word = s_q.ctrl[CB_COINC] ? '0 : data_in;
				end
			end
			CAP_GATE: begin
				if (s_q.ctrl[CB_COINC]) begin
					s_d.word = hit_now;
				end
				if (!s_q.ctrl[CB_COINC] || !ctrl_in[CI_STROBE]) begin
					s_d.st   = s_q.ctrl[CB_DISC] ? CAP_WINDOW : CAP_COPY;
					s_d.wcnt = '0;
				end
			end
			CAP_WINDOW: begin
				s_d.wcnt = s_q.wcnt + 1'b1;
				if (s_q.wcnt >= s_q.win) begin
					s_d.st = CAP_COPY;
				end
			end
			CAP_COPY: begin
				// held until visible and room exists, so no event is lost
				if (copy_in_progress && !f_full && !s_q.ctrl[CB_FTEST]) begin
					s_d.mem[s_q.wp] = s_q.word;
					s_d.wp          = s_q.wp + 1'b1;
					s_d.cnt         = s_d.cnt + 1'b1;
					s_d.st          = CAP_IDLE;
				end
			end
			default: s_d.st = CAP_IDLE;
		endcase
		if (disc_rise && s_q.ctrl[CB_DISC] && s_q.st != CAP_IDLE) begin
			s_d.st = CAP_IDLE;
		end
		if (s_d.st == CAP_IDLE) begin
			s_d.dly = '0;
		end

		// ----------------------------------------------------------------
		// pulser, outputs, indicators
		// ----------------------------------------------------------------
		if (s_q.ctrl[CB_PULSE]) begin
			if (s_q.pcnt == PCNT_W'(PULSER_HALF_CYC - 1)) begin
				s_d.pcnt  = '0;
				s_d.pulse = ~s_q.pulse;
			end else begin
				s_d.pcnt = s_q.pcnt + 1'b1;
			end
		end else begin
			s_d.pcnt  = '0;
			s_d.pulse = 1'b0;
		end

		case (mode)
			2'b00: s_d.outs = {f_full, f_half, f_empty, copy_in_progress};
			2'b01: s_d.outs = {f_full, f_half, s_q.pulse, copy_in_progress};
			2'b10: s_d.outs = {any_hit, s_q.ctrl[CB_USER], s_q.pulse, copy_in_progress};
			default: s_d.outs = {4{s_q.pulse}};
		endcase

		if (!s_q.init_done) begin
			s_d.led = LED_INIT;
			s_d.icnt = s_q.icnt + 1'b1;
			if (s_q.icnt == INIT_W'(INIT_CYC - 1)) begin
				s_d.init_done = 1'b1;
			end
		end else begin
			s_d.led = LED_RUN;
		end

		// front-panel module reset clears capture and fifo, keeps setup
		if (ctrl_in[CI_MODRST]) begin
			s_d.st  = CAP_IDLE;
			s_d.dly = '0;
			s_d.wp  = '0;
			s_d.rp  = '0;
			s_d.cnt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{ctrl: CTRL_RST, win: WIN_RST, addren: ADDREN_RST, st: CAP_IDLE,
			         default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign rsp.prdata  = s_q.prdata;
	assign rsp.pready  = 1'b1;
	assign rsp.pslverr = s_q.pslverr;
	assign ctrl_out    = s_q.outs;
	assign led         = s_q.led;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence gate_start_s;
		s_q.st == CAP_IDLE && gate_rise && !ctrl_in[CI_MODRST];
	endsequence
	sequence cip_wait_s;
		!copy_in_progress [*4] ##1 (copy_in_progress || s_q.st == CAP_IDLE);
	endsequence
	sequence ctrl_write_s;
		acc && am_ok && req.pwrite && req.paddr == OFS_CTRL;
	endsequence

	// ----------------------------------------------------------------
	// output routing
	// ----------------------------------------------------------------
	a_mode0_outputs: assert property (mode == 2'b00 |=>
		ctrl_out == {$past(f_full), $past(f_half), $past(f_empty), $past(copy_in_progress)})
		else $error("mode 0 outputs wrong");
	a_mode1_outputs: assert property (mode == 2'b01 |=>
		ctrl_out == {$past(f_full), $past(f_half), $past(s_q.pulse), $past(copy_in_progress)})
		else $error("mode 1 outputs wrong");
	a_mode2_outputs: assert property (mode == 2'b10 |=>
		ctrl_out[3] == $past(any_hit) && ctrl_out[2] == $past(s_q.ctrl[CB_USER]))
		else $error("mode 2 outputs wrong");
	a_mode3_pulser: assert property (mode == 2'b11 |=>
		ctrl_out == {4{$past(s_q.pulse)}})
		else $error("mode 3 outputs wrong");
	a_cip_out5: assert property (mode != 2'b11 |=> ctrl_out[0] == $past(copy_in_progress))
		else $error("output 5 does not follow copy_in_progress");
	a_reset_mode: assert property ($rose(presetn) |-> mode == 2'b00)
		else $error("mode not zero after reset");

	// ----------------------------------------------------------------
	// capture
	// ----------------------------------------------------------------
	a_strobe_capture: assert property (
		gate_start_s ##0 !s_q.ctrl[CB_COINC] |=> s_q.word == $past(data_in))
		else $error("strobe capture wrong");
	a_coinc_rise_only: assert property (
		s_q.st == CAP_GATE && s_q.ctrl[CB_COINC] |=> (s_q.word & s_q.base) == '0)
		else $error("coincidence stored a non-rising input");
	a_cip_delay: assert property (gate_start_s |=> cip_wait_s)
		else $error("copy_in_progress timing wrong");
	a_discard_ends: assert property (
		copy_in_progress && disc_rise && s_q.ctrl[CB_DISC] |=> !copy_in_progress)
		else $error("discard did not end copy");
	a_modrst_clear: assert property (
		ctrl_in[CI_MODRST] |=> f_empty && s_q.st == CAP_IDLE)
		else $error("module reset did not clear capture and fifo");
	a_pulser_half: assert property (
		$changed(s_q.pulse) && s_q.ctrl[CB_PULSE] |=> $stable(s_q.pulse) [*8])
		else $error("pulser half period short");

	// ----------------------------------------------------------------
	// register bus and fifo
	// ----------------------------------------------------------------
	a_ftest_set: assert property (
		ctrl_write_s ##0 req.pwdata[CB_FTEST] |=> s_q.ctrl[CB_FTEST])
		else $error("fifo test not set");
	a_ftest_clear: assert property (
		ctrl_write_s ##0 (req.pwdata[CB_FTEST + CB_CLR] && !req.pwdata[CB_FTEST])
		|=> !s_q.ctrl[CB_FTEST])
		else $error("fifo test not cleared");
	a_ftest_push: assert property (
		acc && am_ok && req.pwrite && in_fifo && s_q.ctrl[CB_FTEST] && !f_full &&
		!ctrl_in[CI_MODRST] |=> s_q.cnt == $past(s_q.cnt) + 1'b1)
		else $error("test write not pushed");
	a_a24_accepted: assert property (
		setup && mapped && s_q.addren[EN_A24] &&
		(req.am == AM_A24_SBLT || req.am == AM_A24_NBLT ||
		req.am == AM_A24_SDAT || req.am == AM_A24_NDAT) |=> !rsp.pslverr)
		else $error("enabled 24-bit modifier refused");
	a_a32_accepted: assert property (
		setup && mapped && s_q.addren[EN_A32] &&
		(req.am == AM_A32_SBLT || req.am == AM_A32_NBLT ||
		req.am == AM_A32_SDAT || req.am == AM_A32_NDAT) |=> !rsp.pslverr)
		else $error("enabled 32-bit modifier refused");
	a_am_refused: assert property (setup && !am_ok |=> rsp.pslverr)
		else $error("bad modifier answered");
	a_fifo_pop: assert property (
		acc && am_ok && !req.pwrite && in_fifo && !f_empty && s_q.st != CAP_COPY &&
		!ctrl_in[CI_MODRST] |=> s_q.cnt == $past(s_q.cnt) - 1'b1)
		else $error("fifo read did not pop");

	// ----------------------------------------------------------------
	// indicators
	// ----------------------------------------------------------------
	a_led_init: assert property (!s_q.init_done |=> led == LED_INIT)
		else $error("indicators wrong during init");
	a_led_run: assert property (
		s_q.init_done && $past(s_q.init_done) |-> led == LED_RUN)
		else $error("indicators wrong after init");

endmodule // mel_latch_ctl

// [verif/mel_fp_model.sv]
// Purpose: front-panel trigger source for channel levels and control inputs
// Assumes: every change is launched just after a rising pclk edge
// Notes:   input 4 toggles every cycle; the block must ignore it
`timescale 1ns/100ps
module mel_fp_model (
	input  wire logic                  pclk,
	output logic      [mel_pkg::DW-1:0] data_in,
	output logic      [3:0]             ctrl_in
);
	import mel_pkg::*;

	// --------
	// pulse shaping
	// --------
	// 25 ns at 200 MHz; shorter pulses may go unseen
	localparam int MIN_CYC = 5;

	initial begin
		data_in = '0;
		ctrl_in = '0;
	end

	always @(posedge pclk) begin
		ctrl_in[3] <= ~ctrl_in[3];
	end

	task automatic hold(input int n);
		repeat ((n < MIN_CYC) ? MIN_CYC : n) @(posedge pclk);
	endtask

	task automatic level(input logic [DW-1:0] d);
		@(posedge pclk);
		data_in <= d;
	endtask

	task automatic pin(input int i, input int n);
		@(posedge pclk);
		ctrl_in[i] <= 1'b1;
		hold(n);
		ctrl_in[i] <= 1'b0;
	endtask

	// level a before the gate, level b from mid-gate on
	task automatic gate(input logic [DW-1:0] a, input logic [DW-1:0] b, input int n);
		level(a);
		repeat (3) @(posedge pclk);
		ctrl_in[CI_STROBE] <= 1'b1;
		hold(n);
		data_in <= b;
		hold(n);
		ctrl_in[CI_STROBE] <= 1'b0;
	endtask
endmodule // mel_fp_model

// [verif/mel_latch_ctl_tb.sv]
// Purpose: self-checking bench of the latch control block
// Assumes: zero-wait APB slave, short init count in simulation
// Notes:   reads are checked by a monitor against queued notes
`timescale 1ns/100ps
module mel_latch_ctl_tb;
	import mel_pkg::*;

	typedef struct packed {
		logic [DW-1:0] d;
		logic [DW-1:0] m;
		logic          e;
	} mel_note_t;

	localparam int INIT_SIM = 20;
	// strobe sample to output 5, output register included
	localparam int COPY_CYC = CIP_DELAY_CYC;

	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	mel_apb_req_t     req = '0;
	mel_apb_rsp_t     rsp;
	logic [DW-1:0]    data_in;
	logic [3:0]       ctrl_in;
	logic [3:0]       ctrl_out;
	logic [LED_N-1:0] led;
	logic [5:0]       cur_am = AM_A24_NDAT;
	logic [DW-1:0]    rnd = 32'h000056A8;
	logic [DW-1:0]    w;
	logic [DW-1:0]    w2;
	logic [7:0]       exp_mode [3] = '{8'h02, 8'h00, 8'h04};
	logic [5:0]       ams [10] = '{AM_A24_SBLT, AM_A24_SDAT, AM_A24_NBLT, AM_A24_NDAT,
		AM_A16_SUP, AM_A16_NPR, AM_A32_SBLT, AM_A32_SDAT, AM_A32_NBLT, AM_A32_NDAT};
	mel_note_t        notes[$];
	mel_note_t        n;
	int               error_cnt = 0;
	int               checks = 0;
	int               k;

	always #2.5 pclk = ~pclk;

	mel_latch_ctl #(.INIT_CYC(INIT_SIM)) mel_latch_ctl_i (.pclk(pclk), .presetn(presetn),
		.req(req), .rsp(rsp), .data_in(data_in), .ctrl_in(ctrl_in), .ctrl_out(ctrl_out),
		.led(led));
	mel_fp_model mel_fp_model_i (.pclk(pclk), .data_in(data_in), .ctrl_in(ctrl_in));

	// --------
	// helpers
	// --------
	function automatic logic [DW-1:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction

	task automatic fail(input string s);
		error_cnt++;
		$display("Error %0t: %s", $time, s);
	endtask

	task automatic cmp_rd(input mel_note_t x);
		checks++;
		if ((rsp.prdata & x.m) !== (x.d & x.m) || rsp.pslverr !== x.e)
			fail($sformatf("read %h/%b want %h/%b", rsp.prdata, rsp.pslverr, x.d, x.e));
	endtask

	task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp, input string s);
		checks++;
		if (got !== exp)
			fail($sformatf("%s got %h want %h", s, got, exp));
	endtask

	task automatic apb(input logic wr_en, input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr_en, paddr: a, pwdata: d, am: cur_am};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [DW-1:0] m,
		input logic e);
		notes.push_back('{d: d, m: m, e: e});
		apb(1'b0, a, '0);
	endtask

	// set bits n, clear bits n+8; write-one semantics
	task automatic ctl(input logic [CB_N-1:0] s, input logic [CB_N-1:0] c);
		wr(OFS_CTRL, (DW'(c) << CB_CLR) | DW'(s));
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// --------
	// read monitor and watchdog
	// --------
	always @(posedge pclk) begin
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
			if (notes.size() == 0)
				fail("read without note");
			else begin
				n = notes.pop_front();
				cmp_rd(n);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		fail("timeout");
		end_sim();
	end

	// --------
	// tests
	// --------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		cmp_out(led, LED_INIT, "led init");
		cmp_out({4'h0, ctrl_out}, 8'h02, "reset outputs");
		rd(OFS_CTRL, DW'(CTRL_RST), 32'h7F, 1'b0);
		repeat (INIT_SIM + 2) @(posedge pclk);
		#1;
		cmp_out(led, LED_RUN, "led run");
		done("reset");
		foreach (ams[i]) begin
			cur_am = ams[i];
			rd(OFS_CTRL, '0, '0, 1'b0);
		end
		cur_am = 6'h3E;
		rd(OFS_CTRL, '0, '1, 1'b1);
		cur_am = AM_A16_SUP;
		wr(OFS_ADDREN, 32'h5);
		cur_am = AM_A24_SDAT;
		rd(OFS_CTRL, '0, '1, 1'b1);
		cur_am = AM_A32_SDAT;
		wr(OFS_ADDREN, DW'(ADDREN_RST));
		rd(12'h020, '0, '1, 1'b1);
		done("modifiers");
		ctl(7'h02, 7'h00);
		rd(OFS_CTRL, 32'h2, 32'h2, 1'b0);
		w = xs();
		wr(12'h104, w);
		wr(OFS_FIFO_HI, ~w);
		rd(12'h180, w, '1, 1'b0);
		rd(OFS_FIFO_HI, ~w, '1, 1'b0);
		ctl(7'h00, 7'h02);
		rd(OFS_CTRL, 32'h0, 32'h2, 1'b0);
		wr(OFS_FIFO_LO, w);
		rd(OFS_FIFO_LO, '0, '1, 1'b0);
		done("fifo test");
		w = xs();
		fork
			mel_fp_model_i.gate(w, ~w, 5);
			begin
				@(posedge pclk iff ctrl_in[CI_STROBE]);
				k = 0;
				do begin
					@(posedge pclk);
					#1;
					k++;
				end while (ctrl_out[0] !== 1'b1 && k < 20);
				cmp_out(8'(k), 8'(COPY_CYC), "copy delay");
			end
		join
		repeat (10) @(posedge pclk);
		rd(OFS_FIFO_LO, w, '1, 1'b0);
		ctl(7'h10, 7'h00);
		w = xs();
		w2 = xs();
		mel_fp_model_i.gate(w, w2, 5);
		repeat (10) @(posedge pclk);
		rd(OFS_FIFO_LO, w2 & ~w, '1, 1'b0);
		ctl(7'h00, 7'h10);
		mel_fp_model_i.gate(xs() | 32'h1, '0, 5);
		repeat (10) @(posedge pclk);
		mel_fp_model_i.pin(CI_MODRST, 5);
		rd(OFS_FIFO_LO, '0, '1, 1'b0);
		ctl(7'h20, 7'h00);
		mel_fp_model_i.gate(xs() | 32'h1, '0, 5);
		mel_fp_model_i.pin(CI_DISCARD, 5);
		repeat (30) @(posedge pclk);
		rd(OFS_FIFO_LO, '0, '1, 1'b0);
		ctl(7'h00, 7'h20);
		done("capture");
		ctl(7'h01, 7'h00);
		for (int m = 0; m < 3; m++) begin
			ctl(7'(m << CB_MODE0), 7'(((~m) & 3) << CB_MODE0));
			repeat (4) @(posedge pclk);
			#1;
			cmp_out({4'h0, ctrl_out}, exp_mode[m], "mode outputs");
		end
		mel_fp_model_i.level(xs() | 32'h1);
		repeat (4) @(posedge pclk);
		#1;
		cmp_out({4'h0, ctrl_out}, 8'h0C, "any hit");
		ctl(7'h4C, 7'h00);
		repeat (4) @(posedge pclk);
		#1;
		w2[3:0] = ctrl_out;
		k = 0;
		for (int i = 0; i < 40; i++) begin
			@(posedge pclk);
			#1;
			if (ctrl_out !== w2[3:0])
				k++;
			if (ctrl_out !== 4'h0 && ctrl_out !== 4'hF)
				k += 100;
			w2[3:0] = ctrl_out;
		end
		cmp_out(8'(k), 8'(40 / PULSER_HALF_CYC), "pulser");
		done("outputs");
		end_sim();
	end
endmodule // mel_latch_ctl_tb
